/* File: rtl/tgp_glitch_filter.sv */
`timescale 1ns/1ps
`default_nettype none

module tgp_glitch_filter
  import tgp_pkg::*;
(
  input  wire logic              ref_clk,
  input  wire logic              resetn,
  input  wire logic              din,
  input  wire logic [FILT_W-1:0] filt_cyc,
  output var  logic              dout
);

  tgp_filt_t st_r;
  tgp_filt_t st_nxt;

  // The output follows the input only after it has differed for filt_cyc cycles in a row.
  always_comb begin
    st_nxt = st_r;
    if (din == st_r.q) begin
      st_nxt.cnt = '0;
    end else if (st_r.cnt >= filt_cyc - FILT_W'(1)) begin
      st_nxt.q   = din;
      st_nxt.cnt = '0;
    end else begin
      st_nxt.cnt = st_r.cnt + FILT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= FILT_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign dout = st_r.q;

endmodule

`default_nettype wire

/* File: rtl/tgp_pkg.sv */
package tgp_pkg;

  localparam int NP         = 4;
  localparam int NSRC       = 4;
  localparam int PW         = 2;
  localparam int AW         = 8;
  localparam int DW         = 32;
  localparam int FILT_W     = 16;
  localparam int CFG_W      = 8;

  localparam int FILT_TIME_MS  = 1;
  localparam int CLK_KHZ       = 25000;
  localparam int FILT_CYC_DFLT = FILT_TIME_MS * CLK_KHZ;

  localparam logic [AW-1:0] REG_CFG_BASE = 8'h00;
  localparam logic [AW-1:0] REG_CFG_STEP = 8'h04;
  localparam logic [AW-1:0] REG_PERS     = 8'h10;
  localparam logic [AW-1:0] REG_STAT     = 8'h14;
  localparam logic [AW-1:0] REG_OVR      = 8'h18;

  typedef enum logic [2:0] {
    FN_NONE = 3'h0,
    FN_CUT  = 3'h1,
    FN_AUTO = 3'h2,
    FN_KEY  = 3'h3,
    FN_FTB  = 3'h4,
    FN_TC   = 3'h7
  } tgp_func_t;

  typedef struct packed {
    tgp_func_t         func;
    logic [PW-1:0]     src;
    logic              pol;
    logic              level;
    logic              tally;
  } tgp_cfg_t;

  typedef struct packed {
    logic              auto_ign;
    logic              cut_ign;
  } tgp_pers_t;

  typedef struct packed {
    logic [AW-1:0]     addr;
    logic [DW-1:0]     wdata;
    logic              wr;
    logic              rd;
  } tgp_bus_req_t;

  typedef struct packed {
    logic              valid;
    logic [PW-1:0]     port;
    logic              state;
  } tgp_ovr_t;

  typedef struct packed {
    logic              tc_valid;
    logic [NP-1:0]     lvl;
    logic [NP-1:0]     flt;
  } tgp_stat_t;

  typedef struct packed {
    logic [FILT_W-1:0] cnt;
    logic              q;
  } tgp_filt_t;

  typedef struct packed {
    tgp_cfg_t [NP-1:0] cfg;
    tgp_pers_t         pers;
    logic [NP-1:0]     sync1;
    logic [NP-1:0]     sync2;
    logic [NP-1:0]     frame_lvl;
    logic [NP-1:0]     flt_prev;
    logic [NP-1:0]     lvl_state;
    logic [NP-1:0]     fire;
    logic [NP-1:0]     pin_o;
    logic [NP-1:0]     pin_oe_n;
    logic [NP-1:0]     pu_en;
    logic              tc_level;
    logic              tc_valid;
    logic [DW-1:0]     rdata;
  } tgp_state_t;

  localparam tgp_filt_t FILT_RST = '{cnt: '0, q: 1'b1};

  localparam tgp_state_t STATE_RST = '{
    cfg:       '0,
    pers:      '0,
    sync1:     '1,
    sync2:     '1,
    frame_lvl: '1,
    flt_prev:  '1,
    lvl_state: '0,
    fire:      '0,
    pin_o:     '1,
    pin_oe_n:  '1,
    pu_en:     '1,
    tc_level:  1'b1,
    tc_valid:  1'b0,
    rdata:     '0
  };

endpackage

/* File: rtl/tgp_ports.sv */
// What this block does
// - Each port is set on its own as trigger input or tally output.
// - Trigger pulses shorter than 1 ms are filtered out.
// - Edge mode, falling polarity: a high to low change fires the function.
// - Edge mode, rising polarity: a low to high change fires the function.
// - Edge inputs are sampled once per frame, firing at most once a frame.
// - Level mode, active low: function state is on while input is low.
// - Level mode, active high: function state is on while input is high.
// - Level mode holds the element on air, and the opposite level takes it off.
// - Other command sources can override the trigger state in any mode.
// - A tally output follows the on-air flag of one chosen of four inputs.
// - By default a tally rests high and is driven low while on air.
// - Tally polarity inverts the default active low level.
// - Edge or level setting does not affect a tally output.
// - Only one timecode port; a new claim returns the old one to none.
// - Cut and auto behaviour during a running transition applies to edge mode ports only.
//
// Our own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module tgp_ports
  import tgp_pkg::*;
#(
  parameter int FILT_CYC = FILT_CYC_DFLT
)
(
  input  wire logic                ref_clk,
  input  wire logic                resetn,
  input  wire tgp_bus_req_t        bus,
  output var  logic [DW-1:0]       rdata,
  input  wire logic [NP-1:0]       pin_i,
  output var  logic [NP-1:0]       pin_o,
  output var  logic [NP-1:0]       pin_oe_n,
  output var  logic [NP-1:0]       pu_en,
  input  wire logic                frame_start,
  input  wire logic [NSRC-1:0]     on_air,
  input  wire logic                trans_busy,
  input  wire tgp_ovr_t            ovr,
  output var  logic [NP-1:0]       fire,
  output var  tgp_func_t [NP-1:0]  port_func,
  output var  logic [NP-1:0]       lvl_state,
  output var  logic                tc_level,
  output var  logic                tc_valid
);

  localparam logic [FILT_W-1:0] FILT_CYC_W = FILT_W'(FILT_CYC);

  tgp_state_t        st_r;
  tgp_state_t        st_nxt;
  logic [NP-1:0]     flt;
  logic [NP-1:0]     cfg_hit;
  logic [NP-1:0]     tc_claim;
  logic              tc_any;
  logic              rise;
  logic              fall;
  logic              edge_hit;
  logic              act;
  logic              blocked;
  logic              is_trig;
  tgp_cfg_t          cfg_w;
  tgp_stat_t         stat_v;
  tgp_ovr_t          ovr_sw;

  genvar g;
  generate
    for (g = 0; g < NP; g = g + 1) begin : g_port
      tgp_glitch_filter u_filt (
        .ref_clk  (ref_clk),
        .resetn   (resetn),
        .din      (st_r.sync2[g]),
        .filt_cyc (FILT_CYC_W),
        .dout     (flt[g])
      );
    end
  endgenerate

  // Function codes of all ports, taken straight from the configuration flops.
  always_comb begin
    for (int p = 0; p < NP; p++) begin
      port_func[p] = st_r.cfg[p].func;
    end
  end

  always_comb begin
    st_nxt   = st_r;
    cfg_hit  = '0;
    tc_claim = '0;
    tc_any   = 1'b0;
    rise     = 1'b0;
    fall     = 1'b0;
    edge_hit = 1'b0;
    act      = 1'b0;
    blocked  = 1'b0;
    is_trig  = 1'b0;
    cfg_w    = tgp_cfg_t'(bus.wdata[CFG_W-1:0]);
    stat_v   = '0;
    ovr_sw   = '0;

    st_nxt.fire  = '0;
    st_nxt.rdata = '0;

    // Pins come from outside the clock domain.
    st_nxt.sync1 = pin_i;
    st_nxt.sync2 = st_r.sync1;

    for (int p = 0; p < NP; p++) begin
      cfg_hit[p] = (bus.addr == REG_CFG_BASE + AW'(p) * REG_CFG_STEP);
    end

    // Register writes.
    if (bus.wr) begin
      for (int p = 0; p < NP; p++) begin
        if (cfg_hit[p]) begin
          st_nxt.cfg[p] = cfg_w;
          if (!cfg_w.tally && cfg_w.func == FN_TC) begin
            tc_claim[p] = 1'b1;
          end
        end
      end
      if (bus.addr == REG_PERS) begin
        st_nxt.pers = tgp_pers_t'(bus.wdata[$bits(tgp_pers_t)-1:0]);
      end
      if (bus.addr == REG_OVR) begin
        ovr_sw = tgp_ovr_t'({1'b1, bus.wdata[PW:0]});
      end
    end

    // A new timecode claim frees any other timecode port.
    for (int p = 0; p < NP; p++) begin
      if ((|tc_claim) && !tc_claim[p] && st_nxt.cfg[p].func == FN_TC) begin
        st_nxt.cfg[p].func = FN_NONE;
      end
    end

    // Per port behaviour.
    for (int p = 0; p < NP; p++) begin
      is_trig = !st_r.cfg[p].tally;
      act     = st_r.cfg[p].pol ? flt[p] : ~flt[p];
      rise    = !st_r.frame_lvl[p] && flt[p];
      fall    = st_r.frame_lvl[p] && !flt[p];
      edge_hit = st_r.cfg[p].pol ? rise : fall;
      blocked = trans_busy &&
                ((st_r.cfg[p].func == FN_CUT && st_r.pers.cut_ign) ||
                 (st_r.cfg[p].func == FN_AUTO && st_r.pers.auto_ign));

      st_nxt.flt_prev[p] = flt[p];

      if (is_trig) begin
        st_nxt.pin_oe_n[p] = 1'b1;
        st_nxt.pin_o[p]    = 1'b1;
        st_nxt.pu_en[p]    = 1'b1;
      end else begin
        st_nxt.pin_oe_n[p] = 1'b0;
        st_nxt.pin_o[p]    = ~on_air[st_r.cfg[p].src] ^ st_r.cfg[p].pol;
        st_nxt.pu_en[p]    = 1'b0;
      end

      // Edge inputs are looked at only on the frame boundary.
      if (frame_start) begin
        st_nxt.frame_lvl[p] = flt[p];
      end

      if (!is_trig || st_r.cfg[p].func == FN_NONE || st_r.cfg[p].func == FN_TC) begin
        st_nxt.lvl_state[p] = 1'b0;
      end else if (!st_r.cfg[p].level) begin
        if (frame_start && edge_hit && !blocked) begin
          st_nxt.fire[p] = 1'b1;
        end
      end else if (flt[p] != st_r.flt_prev[p]) begin
        st_nxt.lvl_state[p] = act;
      end

      // Commands from other sources take precedence over the pin.
      if (is_trig && st_r.cfg[p].func != FN_NONE && st_r.cfg[p].func != FN_TC) begin
        if (ovr.valid && ovr.port == PW'(p)) begin
          st_nxt.lvl_state[p] = ovr.state;
        end else if (ovr_sw.valid && ovr_sw.port == PW'(p)) begin
          st_nxt.lvl_state[p] = ovr_sw.state;
        end
      end
    end

    // Timecode passes the synchronised pin without filtering.
    st_nxt.tc_level = 1'b1;
    for (int p = 0; p < NP; p++) begin
      if (!st_r.cfg[p].tally && st_r.cfg[p].func == FN_TC) begin
        tc_any          = 1'b1;
        st_nxt.tc_level = st_r.sync2[p];
      end
    end
    st_nxt.tc_valid = tc_any;

    // Register reads answer in the next cycle only.
    stat_v.tc_valid = st_r.tc_valid;
    stat_v.lvl      = st_r.lvl_state;
    stat_v.flt      = flt;
    if (bus.rd) begin
      for (int p = 0; p < NP; p++) begin
        if (cfg_hit[p]) begin
          st_nxt.rdata = DW'(st_r.cfg[p]);
        end
      end
      if (bus.addr == REG_PERS) begin
        st_nxt.rdata = DW'(st_r.pers);
      end
      if (bus.addr == REG_STAT) begin
        st_nxt.rdata = DW'(stat_v);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      st_r <= STATE_RST;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign rdata     = st_r.rdata;
  assign pin_o     = st_r.pin_o;
  assign pin_oe_n  = st_r.pin_oe_n;
  assign pu_en     = st_r.pu_en;
  assign fire      = st_r.fire;
  assign lvl_state = st_r.lvl_state;
  assign tc_level  = st_r.tc_level;
  assign tc_valid  = st_r.tc_valid;

endmodule

`default_nettype wire

/* File: tb/tgp_ports_chk.sv */
`timescale 1ns/1ps
`default_nettype none

module tgp_ports_chk
  import tgp_pkg::*;
#(
  parameter int FILT_CYC = FILT_CYC_DFLT
)
(
  input wire logic               ref_clk,
  input wire logic               resetn,
  input wire tgp_bus_req_t       bus,
  input wire logic [NP-1:0]      pin_i,
  input wire logic [NP-1:0]      pin_o,
  input wire logic [NP-1:0]      pin_oe_n,
  input wire logic [NP-1:0]      pu_en,
  input wire logic               frame_start,
  input wire tgp_ovr_t           ovr,
  input wire logic [NP-1:0]      fire,
  input wire tgp_func_t [NP-1:0] port_func,
  input wire logic [NP-1:0]      lvl_state
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  logic [NP-1:0]     is_tc;
  logic [FILT_W-1:0] stab_r;
  logic              pin2_r;

  always_comb begin
    for (int i = 0; i < NP; i++) begin
      is_tc[i] = (port_func[i] == FN_TC) && pin_oe_n[i];
    end
  end

  // Counts the cycles that the pin of port 2 has held its level.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      pin2_r <= 1'b1;
      stab_r <= '0;
    end else begin
      pin2_r <= pin_i[2];
      stab_r <= (pin_i[2] != pin2_r) ? '0 : ((&stab_r) ? stab_r : stab_r + FILT_W'(1));
    end
  end

  property p_fire_frame;
    |fire |-> $past(frame_start);
  endproperty
  a_fire_frame: assert property (p_fire_frame) else $error("fire without frame start");
  property p_fire_once;
    |fire |=> fire == '0;
  endproperty
  a_fire_once: assert property (p_fire_once) else $error("fire longer than one cycle");
  property p_pullup;
    (pu_en & pin_oe_n) == pin_oe_n;
  endproperty
  a_pullup: assert property (p_pullup) else $error("input port without pull-up");
  property p_trig_idle;
    (pin_o & pin_oe_n) == pin_oe_n;
  endproperty
  a_trig_idle: assert property (p_trig_idle) else $error("input port drive not high");
  property p_tally_lvl;
    (lvl_state & ~pin_oe_n) == '0;
  endproperty
  a_tally_lvl: assert property (p_tally_lvl) else $error("tally port has state");
  property p_ovr;
    ovr.valid && pin_oe_n[ovr.port] && port_func[ovr.port] inside {FN_CUT, FN_AUTO, FN_KEY, FN_FTB}
      |=> lvl_state[$past(ovr.port)] == $past(ovr.state);
  endproperty
  a_ovr: assert property (p_ovr) else $error("override not taken");
  property p_tc_one;
    $onehot0(is_tc);
  endproperty
  a_tc_one: assert property (p_tc_one) else $error("two timecode ports");
  property p_filter;
    $rose(lvl_state[2]) && !$past(ovr.valid) && !$past(bus.wr) |-> stab_r >= FILT_CYC;
  endproperty
  a_filter: assert property (p_filter) else $error("short pulse passed filter");
endmodule

bind tgp_ports tgp_ports_chk #(.FILT_CYC(FILT_CYC)) chk_u (.ref_clk, .resetn, .bus, .pin_i,
  .pin_o, .pin_oe_n, .pu_en, .frame_start, .ovr, .fire, .port_func, .lvl_state);

`default_nettype wire

/* File: tb/tgp_ports_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tgp_ports_tb
  import tgp_pkg::*;
;
  localparam int FC = 8;
  logic               ref_clk = 1'b0, resetn = 1'b0, frame_start = 1'b0, trans_busy = 1'b0;
  logic               tc_level, tc_valid;
  tgp_bus_req_t       bus = '0;
  tgp_ovr_t           ovr = '0;
  logic [DW-1:0]      rdata;
  logic [NP-1:0]      pin_i, pin_o, pin_oe_n, pu_en, fire, lvl_state, press = '0;
  logic [NSRC-1:0]    on_air = '0;
  tgp_func_t [NP-1:0] port_func;
  int                 n_errors = 0, n_compared = 0;

  always #20 ref_clk = ~ref_clk;

  tgp_ports #(.FILT_CYC(FC)) dut_u (.ref_clk, .resetn, .bus, .rdata, .pin_i, .pin_o,
    .pin_oe_n, .pu_en, .frame_start, .on_air, .trans_busy, .ovr, .fire, .port_func,
    .lvl_state, .tc_level, .tc_valid);
  tgp_switch_model sw_u (.ref_clk, .press, .pin_o, .pin_oe_n, .pu_en, .pin_i);

  task automatic stop_test;
    if (n_errors == 0 && n_compared > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [DW-1:0] s, input logic [DW-1:0] e);
    n_compared++;
    if (s !== e) begin
      n_errors++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d);
    @(posedge ref_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge ref_clk) bus <= '0;
  endtask
  task automatic rd(input logic [AW-1:0] a, input logic [DW-1:0] e);
    @(posedge ref_clk) bus <= '{addr: a, wdata: '0, wr: 1'b0, rd: 1'b1};
    @(posedge ref_clk) bus <= '0;
    #1 chk("rdata", rdata, e);
  endtask
  // Sets a switch and waits until the filtered level has settled.
  task automatic pr(input int p, input logic v);
    @(posedge ref_clk) press[p] <= v;
    tk(FC + 6);
  endtask
  task automatic frm(input logic [NP-1:0] e);
    logic [NP-1:0] acc;
    acc = '0;
    @(posedge ref_clk) frame_start <= 1'b1;
    @(posedge ref_clk) frame_start <= 1'b0;
    repeat (3) @(negedge ref_clk) acc = acc | fire;
    chk("fire", DW'(acc), DW'(e));
  endtask
  task automatic air(input logic [NSRC-1:0] v, input logic [DW-1:0] e);
    @(posedge ref_clk) on_air <= v;
    tk(2);
    #1 chk("pin_o", DW'(pin_o), e);
  endtask

  initial begin
    tk(6);
    resetn <= 1'b1;
    rd(REG_STAT, 32'h0f);
    rd(8'h40, 32'h0);
    wr(8'h40, 32'hff);
    wr(REG_CFG_BASE, 32'h20);
    wr(8'h04, 32'h11);
    wr(8'h08, 32'h66);
    wr(8'h0c, 32'he0);
    rd(8'h04, 32'h11);
    chk("oe", DW'(pin_oe_n), 32'hd);
    chk("tcv", DW'(tc_valid), 32'h1);
    chk("pu", DW'(pu_en), 32'hd);
    @(posedge ref_clk) press[3] <= 1'b1;
    tk(4);
    #1 chk("tc_level", DW'(tc_level), 32'h0);
    @(posedge ref_clk) press[3] <= 1'b0;
    air(4'hb, 32'hf);
    air(4'h4, 32'hd);
    wr(8'h04, 32'h17);
    air(4'h4, 32'hf);
    pr(0, 1'b1);
    frm(4'h1);
    frm(4'h0);
    pr(0, 1'b0);
    frm(4'h0);
    wr(REG_CFG_BASE, 32'h24);
    pr(0, 1'b1);
    frm(4'h0);
    pr(0, 1'b0);
    frm(4'h1);
    @(posedge ref_clk) press[0] <= 1'b1;
    tk(FC - 3);
    press[0] <= 1'b0;
    rd(REG_STAT, 32'h10f);
    tk(FC + 6);
    frm(4'h0);
    pr(2, 1'b1);
    pr(2, 1'b0);
    chk("lvl", DW'(lvl_state[2]), 32'h1);
    wr(8'h08, 32'h62);
    pr(2, 1'b1);
    chk("lvl", DW'(lvl_state[2]), 32'h1);
    pr(2, 1'b0);
    chk("lvl", DW'(lvl_state[2]), 32'h0);
    @(posedge ref_clk) ovr <= '{valid: 1'b1, port: 2'h2, state: 1'b1};
    @(posedge ref_clk) ovr <= '0;
    #1 chk("lvl", DW'(lvl_state[2]), 32'h1);
    wr(REG_CFG_BASE, 32'he0);
    rd(8'h0c, 32'h0);
    chk("port_func", DW'(port_func), 32'h0c7);
    chk("tc_level", DW'(tc_level), 32'h1);
    wr(REG_CFG_BASE, 32'h20);
    wr(REG_PERS, 32'h1);
    @(posedge ref_clk) trans_busy <= 1'b1;
    pr(0, 1'b1);
    frm(4'h0);
    wr(REG_PERS, 32'h0);
    pr(0, 1'b0);
    frm(4'h0);
    pr(0, 1'b1);
    frm(4'h1);
    wr(REG_CFG_BASE, 32'h40);
    wr(REG_PERS, 32'h2);
    rd(REG_PERS, 32'h2);
    pr(0, 1'b0);
    frm(4'h0);
    pr(0, 1'b1);
    frm(4'h0);
    stop_test();
  end

  initial begin
    tk(5000);
    n_errors++;
    stop_test();
  end
endmodule

`default_nettype wire

/* File: tb/tgp_switch_model.sv */
`timescale 1ns/1ps
`default_nettype none

module tgp_switch_model
  import tgp_pkg::*;
(
  input  wire logic          ref_clk,
  input  wire logic [NP-1:0] press,
  input  wire logic [NP-1:0] pin_o,
  input  wire logic [NP-1:0] pin_oe_n,
  input  wire logic [NP-1:0] pu_en,
  output var  logic [NP-1:0] pin_i
);
  logic tog = 1'b0;

  always @(posedge ref_clk) tog <= ~tog;

  // A closed switch grounds the pin; an open one leaves it to the pull-up.
  always_comb begin
    for (int i = 0; i < NP; i++) begin
      if (!pin_oe_n[i]) pin_i[i] = pin_o[i];
      else if (press[i]) pin_i[i] = 1'b0;
      else pin_i[i] = pu_en[i] ? 1'b1 : tog;
    end
  end
endmodule

`default_nettype wire
